// ### design/ssmt_pkg.sv
package ssmt_pkg;

	// ********************************************************************
	// Widths and bus codes
	// ********************************************************************
	localparam int unsigned DW  = 16;
	localparam int unsigned ADW = 8;
	localparam int unsigned NMV = 2;
	localparam logic [1:0] HT_NONSEQ = 2'h2;
	localparam logic [1:0] HT_SEQ    = 2'h3;
	localparam logic       HRESP_OK  = 1'h0;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam logic [ADW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [ADW-1:0] ADDR_LSP  = 8'h04;
	localparam logic [ADW-1:0] ADDR_MAN [NMV] = '{8'h08, 8'h0c};
	localparam logic [ADW-1:0] ADDR_STAT = 8'h10;

	// ********************************************************************
	// Setting codes
	// ********************************************************************
	localparam logic [1:0] EXT_REMOTE  = 2'h0;
	localparam logic [1:0] EXT_CASCADE = 2'h1;
	localparam logic [1:0] EXT_RATIO   = 2'h2;
	localparam logic [1:0] PROTO_INTER = 2'h2;
	localparam logic [1:0] MVX_BUMPLESS = 2'h0;
	localparam logic [1:0] MVX_PIN_PREV = 2'h1;
	localparam logic [1:0] MVX_PREV     = 2'h2;

	// ********************************************************************
	// Carriers
	// ********************************************************************
	typedef struct packed {
		logic [13:0] rsv_hi;
		logic [1:0]  second_port_protocol;
		logic [2:0]  rsv_mid;
		logic [4:0]  master_channel_select;
		logic [1:0]  rsv_lo;
		logic        meas_xfer_en;
		logic [1:0]  mv_xfer_mode;
		logic        track_en;
		logic [1:0]  ext_type;
	} ssmt_ctrl_t;

	localparam ssmt_ctrl_t CTRL_RST = '{
		rsv_hi: 14'h0, second_port_protocol: 2'h0, rsv_mid: 3'h0,
		master_channel_select: 5'h00, rsv_lo: 2'h0, meas_xfer_en: 1'h0,
		mv_xfer_mode: MVX_BUMPLESS, track_en: 1'h1, ext_type: EXT_REMOTE};

	typedef struct packed {
		logic [27:0] rsv;
		logic        master_seen;
		logic        cascade_on;
		logic        manual;
		logic        remote;
	} ssmt_stat_t;

	typedef struct packed {
		logic          remote;
		logic          manual;
		logic          by_pin;
	} ssmt_mode_t;

	typedef struct packed {
		logic          vld;
		logic [4:0]    addr;
		logic [DW-1:0] setp;
	} ssmt_link_t;

endpackage

// ### design/ssmt_core.sv
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps

// Contract
// - Input type: remote input (0), cascade (1) or ratio (2); default 0.
// - Cascade or ratio works only with port 2 present and its protocol at 2.
// - A slave uses code 1 for cascade and code 2 for ratio.
// - The master channel holds the master's second address, 0..31, default 0.
// - In cascade or ratio only link data from the matching address is taken.
// - The master channel counts only while ext input type is 1 or 2.
// - Setpoint tracking enable defaults to 1 (used).
// - With tracking on, remote-to-local copies the remote setpoint to local.
// - Local uses local setpoint, remote uses remote; no tracking, no copy.
// - Auto-to-manual picks the starting manual value by a 3-way setting.
// - Code 0 starts at auto; code 1 keeps old manual if by pin, else auto.
// - Setting 2 always starts at the value of the previous manual period.
// - Measured value transfer enable defaults to 0 (unused).
// - With it on, manual-to-auto loads the measured value into the setpoint; a tracked remote-to-local copy in the same cycle wins.
module ssmt_core (
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	input  wire logic                   port2_ready,
	input  wire ssmt_pkg::ssmt_mode_t   mode_in,
	input  wire ssmt_pkg::ssmt_link_t   link_in,
	input  wire logic [ssmt_pkg::DW-1:0] remote_setpoint_input,
	input  wire logic [ssmt_pkg::DW-1:0] measured_value,
	input  wire logic [ssmt_pkg::DW-1:0] auto_first_mv,
	input  wire logic [ssmt_pkg::DW-1:0] auto_second_mv,
	output logic      [ssmt_pkg::DW-1:0] setpoint_value,
	output logic      [ssmt_pkg::DW-1:0] first_manipulated_value,
	output logic      [ssmt_pkg::DW-1:0] second_manipulated_value
);
	import ssmt_pkg::*;

	// ********************************************************************
	// Declarations
	// ********************************************************************
	ssmt_ctrl_t     ctrl_r;
	ssmt_stat_t     stat;
	ssmt_mode_t     prev_r;
	logic [31:0]    hrdata_r;
	logic           hreadyout_r;
	logic           hresp_r;
	logic           wr_pend_r;
	logic           rd_pend_r;
	logic [ADW-1:0] wr_addr_r;
	logic [ADW-1:0] rd_addr_r;
	logic [DW-1:0]  lsp_r;
	logic [DW-1:0]  lsp_nxt;
	logic [DW-1:0]  master_setp_r;
	logic           master_seen_r;
	logic [DW-1:0]  setp_r;
	ssmt_ctrl_t     wr_ctrl;
	logic [DW-1:0]  rsp_use;
	logic [DW-1:0]  man_r   [NMV];
	logic [DW-1:0]  man_nxt [NMV];
	logic [DW-1:0]  mv_r    [NMV];
	logic [DW-1:0]  auto_mv [NMV];
	logic           addr_ok;
	logic           take;
	logic           wr_lsp;
	logic           cascade_ok;
	logic           link_take;
	logic           rem2loc;
	logic           a2m;
	logic           m2a;

	assign hrdata    = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp     = hresp_r;
	assign setpoint_value           = setp_r;
	assign first_manipulated_value  = mv_r[0];
	assign second_manipulated_value = mv_r[1];
	assign auto_mv[0] = auto_first_mv;
	assign auto_mv[1] = auto_second_mv;

	// ********************************************************************
	// AHB-Lite slave: zero-wait writes, one wait state on reads
	// ********************************************************************
	assign addr_ok = (htrans == HT_NONSEQ) || (htrans == HT_SEQ);
	assign take    = hsel && hready && addr_ok;
	assign wr_lsp  = wr_pend_r && (wr_addr_r == ADDR_LSP);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_pend_r <= 1'h0;
			rd_pend_r <= 1'h0;
			wr_addr_r <= '0;
			rd_addr_r <= '0;
		end else begin
			wr_pend_r <= take && hwrite;
			rd_pend_r <= take && !hwrite;
			if (take) begin
				wr_addr_r <= haddr[ADW-1:0];
				rd_addr_r <= haddr[ADW-1:0];
			end
		end
	end

	// Read data sampled a cycle late so a write just before is seen
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hreadyout_r <= 1'h1;
			hresp_r     <= HRESP_OK;
			hrdata_r    <= '0;
		end else begin
			hresp_r     <= HRESP_OK;
			hreadyout_r <= !(take && !hwrite);
			if (rd_pend_r) begin
				case (rd_addr_r)
					ADDR_CTRL:   hrdata_r <= ctrl_r;
					ADDR_LSP:    hrdata_r <= 32'(lsp_r);
					ADDR_MAN[0]: hrdata_r <= 32'(man_r[0]);
					ADDR_MAN[1]: hrdata_r <= 32'(man_r[1]);
					ADDR_STAT:   hrdata_r <= stat;
					default:     hrdata_r <= '0;
				endcase
			end
		end
	end

	// ********************************************************************
	// Settings register
	// ********************************************************************
	assign wr_ctrl = ssmt_ctrl_t'(hwdata);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_pend_r && wr_addr_r == ADDR_CTRL) begin
			ctrl_r <= CTRL_RST;
			ctrl_r.ext_type <= wr_ctrl.ext_type;
			ctrl_r.track_en <= wr_ctrl.track_en;
			ctrl_r.mv_xfer_mode <= wr_ctrl.mv_xfer_mode;
			ctrl_r.meas_xfer_en <= wr_ctrl.meas_xfer_en;
			ctrl_r.master_channel_select <=
				wr_ctrl.master_channel_select;
			ctrl_r.second_port_protocol <=
				wr_ctrl.second_port_protocol;
		end
	end

	assign stat = '{rsv: 28'h0, master_seen: master_seen_r,
		cascade_on: cascade_ok, manual: prev_r.manual,
		remote: prev_r.remote};

	// ********************************************************************
	// Setpoint source
	// ********************************************************************
	assign cascade_ok = port2_ready &&
		(ctrl_r.second_port_protocol == PROTO_INTER) &&
		((ctrl_r.ext_type == EXT_CASCADE) ||
		 (ctrl_r.ext_type == EXT_RATIO));
	assign link_take = link_in.vld && cascade_ok &&
		(link_in.addr == ctrl_r.master_channel_select);
	// Ratio scaling is done downstream; the master value passes raw
	assign rsp_use = cascade_ok ? master_setp_r
		: remote_setpoint_input;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			master_setp_r <= '0;
			master_seen_r <= 1'h0;
		end else if (link_take) begin
			master_setp_r <= link_in.setp;
			master_seen_r <= 1'h1;
		end else if (!cascade_ok) begin
			master_seen_r <= 1'h0;
		end
	end

	// ********************************************************************
	// Mode transitions, one-cycle events
	// ********************************************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_r <= '0;
		end else begin
			prev_r <= mode_in;
		end
	end

	assign rem2loc = prev_r.remote && !mode_in.remote;
	assign a2m     = !prev_r.manual && mode_in.manual;
	assign m2a     = prev_r.manual && !mode_in.manual;

	// ********************************************************************
	// Local setpoint and setpoint output
	// ********************************************************************
	// Hardware hand-overs win over a software write in the same cycle
	always_comb begin
		lsp_nxt = lsp_r;
		if (rem2loc && ctrl_r.track_en) begin
			lsp_nxt = rsp_use;
		end else if (m2a && ctrl_r.meas_xfer_en) begin
			lsp_nxt = measured_value;
		end else if (wr_lsp) begin
			lsp_nxt = hwdata[DW-1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lsp_r  <= '0;
			setp_r <= '0;
		end else begin
			lsp_r  <= lsp_nxt;
			setp_r <= mode_in.remote ? rsp_use : lsp_nxt;
		end
	end

	// ********************************************************************
	// Manual manipulated values, one per output
	// ********************************************************************
	for (genvar g = 0; g < NMV; g++) begin : g_mv
		always_comb begin
			man_nxt[g] = man_r[g];
			if (a2m) begin
				case (ctrl_r.mv_xfer_mode)
					MVX_BUMPLESS: man_nxt[g] = auto_mv[g];
					MVX_PIN_PREV: begin
						if (!mode_in.by_pin) begin
							man_nxt[g] = auto_mv[g];
						end
					end
					MVX_PREV: man_nxt[g] = man_r[g];
					default:  man_nxt[g] = man_r[g];
				endcase
			end else if (wr_pend_r && wr_addr_r == ADDR_MAN[g]) begin
				man_nxt[g] = hwdata[DW-1:0];
			end
		end

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				man_r[g] <= '0;
				mv_r[g]  <= '0;
			end else begin
				man_r[g] <= man_nxt[g];
				mv_r[g]  <= mode_in.manual ? man_nxt[g] : auto_mv[g];
			end
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_track_copy: assert property (
		rem2loc && ctrl_r.track_en |=> lsp_r == $past(rsp_use))
		else $error("tracking did not copy remote setpoint");
	a_track_off: assert property (
		rem2loc && !ctrl_r.track_en && !m2a && !wr_lsp |=> $stable(lsp_r))
		else $error("local setpoint moved without tracking");
	a_remote_sel: assert property (
		mode_in.remote && !cascade_ok
		|=> setp_r == $past(remote_setpoint_input))
		else $error("remote mode not using remote setpoint");
	a_cascade_gate: assert property (
		!port2_ready || ctrl_r.second_port_protocol != PROTO_INTER
		|-> rsp_use == remote_setpoint_input)
		else $error("cascade used without link port");
	a_mch_ignored: assert property (
		ctrl_r.ext_type == EXT_REMOTE |-> !cascade_ok)
		else $error("master channel active in remote type");
	a_master_match: assert property (
		link_in.vld && link_in.addr != ctrl_r.master_channel_select
		|=> $stable(master_setp_r))
		else $error("link data taken from wrong address");
	a_bumpless: assert property (
		a2m && ctrl_r.mv_xfer_mode == MVX_BUMPLESS
		|=> man_r[0] == $past(auto_mv[0]) && man_r[1] == $past(auto_mv[1]))
		else $error("bumpless start not at auto value");
	a_pin_prev: assert property (
		a2m && ctrl_r.mv_xfer_mode == MVX_PIN_PREV && mode_in.by_pin
		|=> man_r[1] == $past(man_r[1]))
		else $error("digital input start not previous manual");
	a_prev_manual: assert property (
		a2m && ctrl_r.mv_xfer_mode == MVX_PREV
		|=> mv_r[0] == $past(man_r[0]))
		else $error("manual start not previous manual value");
	a_meas_load: assert property (
		m2a && ctrl_r.meas_xfer_en && !(rem2loc && ctrl_r.track_en)
		|=> lsp_r == $past(measured_value))
		else $error("measured value not loaded");
	a_hand_once: assert property (
		!rem2loc && !m2a && !wr_lsp |=> $stable(lsp_r))
		else $error("setpoint changed outside transition");
	a_bus_okay: assert property (
		hresp == HRESP_OK && (!rd_pend_r || !hreadyout))
		else $error("bus answer not okay");

	c_track: cover property (rem2loc && ctrl_r.track_en);
	c_a2m_pin: cover property (a2m && mode_in.by_pin);
	c_meas_xfer: cover property (m2a && ctrl_r.meas_xfer_en);
	c_link: cover property (link_take ##1 mode_in.remote);

endmodule

// ### bench/ssmt_master_model.sv
`timescale 1ns/100ps

// ********************************************************************
// Master controller on the intercontroller link
// ********************************************************************
module ssmt_master_model
	import ssmt_pkg::*;
#(
	parameter logic [1:0] OWN_EXT_TYPE = EXT_REMOTE
) (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic                    send,
	input  wire logic [4:0]              addr,
	input  wire logic [ssmt_pkg::DW-1:0] setp,
	output ssmt_pkg::ssmt_link_t         link
);
	import ssmt_pkg::*;

	// Idle fields flip every cycle so stale data never looks valid
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			link <= '0;
		end else if (send && OWN_EXT_TYPE == EXT_REMOTE) begin
			link <= '{vld: 1'b1, addr: addr, setp: setp};
		end else begin
			link <= '{vld: 1'b0, addr: ~link.addr, setp: ~link.setp};
		end
	end
endmodule

// ### bench/testbench.sv
`timescale 1ns/100ps

// ********************************************************************
// Bench top
// ********************************************************************
module testbench;
	import ssmt_pkg::*;
	logic          clk, rstn, hsel, hwrite, hreadyout, hresp;
	logic          port2_ready, send, keep;
	logic [31:0]   haddr, hwdata, hrdata, rd;
	logic [1:0]    htrans;
	logic [2:0]    hsize;
	logic [4:0]    s_addr;
	logic [DW-1:0] s_setp, rsi, meas, amv1, amv2, sp, mv1, mv2, e1;
	ssmt_mode_t    mode_in;
	ssmt_link_t    link_in;
	int            fails, check_count;

	ssmt_core u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .port2_ready(port2_ready), .mode_in(mode_in),
		.link_in(link_in), .remote_setpoint_input(rsi), .measured_value(meas),
		.auto_first_mv(amv1), .auto_second_mv(amv2), .setpoint_value(sp),
		.first_manipulated_value(mv1), .second_manipulated_value(mv2));

	ssmt_master_model u_master (.clk(clk), .rstn(rstn), .send(send),
		.addr(s_addr), .setp(s_setp), .link(link_in));

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Sample ready on the low phase so the edge itself is never raced
	task automatic wait_rdy;
		logic r;
		r = 1'b0;
		for (int i = 0; i < 50 && !r; i++) begin
			@(negedge clk);
			r = (hreadyout === 1'b1);
			rd = hrdata;
			@(posedge clk);
		end
		if (!r) begin
			fails++;
			summarize();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HT_NONSEQ;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask

	function automatic logic [31:0] cw(input logic [1:0] e, input logic t,
		input logic [1:0] x, input logic p, input logic [4:0] c,
		input logic [1:0] q);
		return {14'h0, q, 3'h0, c, 2'h0, p, x, t, e};
	endfunction

	task automatic set_mode(input logic r, m, d);
		@(posedge clk);
		mode_in <= '{remote: r, manual: m, by_pin: d};
		step(3);
	endtask

	task automatic xmit(input logic [4:0] a, input logic [DW-1:0] v);
		@(posedge clk);
		send <= 1'b1;
		s_addr <= a;
		s_setp <= v;
		@(posedge clk);
		send <= 1'b0;
		step(3);
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		port2_ready = 1'b0;
		send = 1'b0;
		s_addr = 5'h00;
		s_setp = 16'h0;
		mode_in = '0;
		rsi = 16'h0aaa;
		meas = 16'h0555;
		amv1 = 16'h0a01;
		amv2 = 16'h0a02;
		fails = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl_rst", rd, 32'h4);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", rd, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'hffffffff);
		bus(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl_rw", rd, 32'h31f3f);
		// ************************************************************
		// Setpoint source and tracking
		// ************************************************************
		bus(1'b1, ADDR_CTRL, cw(2'h0, 1'b1, 2'h0, 1'b0, 5'h00, 2'h0));
		bus(1'b1, ADDR_LSP, 32'h1234);
		step(2);
		chk("sp_local", sp, 16'h1234);
		set_mode(1'b1, 1'b0, 1'b0);
		chk("sp_remote", sp, rsi);
		set_mode(1'b0, 1'b0, 1'b0);
		chk("sp_track", sp, 16'h0aaa);
		@(posedge clk);
		rsi <= 16'h0bbb;
		step(2);
		chk("sp_once", sp, 16'h0aaa);
		bus(1'b0, ADDR_LSP, 32'h0);
		chk("lsp_track", rd, 32'h0aaa);
		bus(1'b1, ADDR_CTRL, cw(2'h0, 1'b0, 2'h0, 1'b0, 5'h00, 2'h0));
		bus(1'b1, ADDR_LSP, 32'h1234);
		set_mode(1'b1, 1'b0, 1'b0);
		set_mode(1'b0, 1'b0, 1'b0);
		chk("sp_notrack", sp, 16'h1234);
		// ************************************************************
		// Link source selection per input type
		// ************************************************************
		for (int e = 0; e < 3; e++) begin
			bus(1'b1, ADDR_CTRL, cw(e[1:0], 1'b1, 2'h0, 1'b0, 5'h1f, PROTO_INTER));
			port2_ready <= 1'b1;
			set_mode(1'b1, 1'b0, 1'b0);
			e1 = (e != 0) ? 16'h0700 + 16'(e) : rsi;
			xmit(5'h1f, 16'h0700 + 16'(e));
			chk("casc_take", sp, e1);
			bus(1'b0, ADDR_STAT, 32'h0);
			chk("stat", rd, (e != 0) ? 32'hd : 32'h1);
			chk("hresp", 32'(hresp), 32'h0);
			xmit(5'h1e, 16'h0999);
			chk("casc_other", sp, e1);
			@(posedge clk);
			port2_ready <= 1'b0;
			step(3);
			chk("casc_port", sp, rsi);
			set_mode(1'b0, 1'b0, 1'b0);
		end
		// ************************************************************
		// Manual value hand-over for every transfer code
		// ************************************************************
		for (int m = 0; m < 3; m++) begin
			for (int d = 0; d < 2; d++) begin
				bus(1'b1, ADDR_CTRL, cw(2'h0, 1'b1, m[1:0], 1'b0, 5'h00, 2'h0));
				bus(1'b1, ADDR_MAN[0], 32'h0111);
				bus(1'b1, ADDR_MAN[1], 32'h0222);
				set_mode(1'b0, 1'b1, d[0]);
				keep = (m == 2) || (m == 1 && d == 1);
				e1 = keep ? 16'h0111 : amv1;
				chk("mv1", mv1, e1);
				chk("mv2", mv2, keep ? 16'h0222 : amv2);
				@(posedge clk);
				amv1 <= amv1 ^ 16'h00ff;
				step(2);
				chk("mv1_hold", mv1, e1);
				set_mode(1'b0, 1'b0, 1'b0);
				chk("mv1_auto", mv1, amv1);
			end
		end
		// ************************************************************
		// Measured value into setpoint
		// ************************************************************
		bus(1'b1, ADDR_CTRL, cw(2'h0, 1'b1, 2'h0, 1'b1, 5'h00, 2'h0));
		set_mode(1'b0, 1'b1, 1'b0);
		set_mode(1'b0, 1'b0, 1'b0);
		chk("meas_xfer", sp, 16'h0555);
		@(posedge clk);
		meas <= 16'h0666;
		step(2);
		chk("meas_once", sp, 16'h0555);
		summarize();
	end
endmodule
